// ### shared/cim_pkg.sv
// Purpose: constants for the control input function mapper
// Assumes: 20 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: selection byte = {b_contact, function[6:0]}, one byte each for position, velocity and torque modes
// Behaviour
// - any assignable function except deviation clear may be routed to any general input by configuration
// - each input has its own contact polarity setting
// - a-contact: open means function OFF, connected to return means ON
// - b-contact: open means function ON, connected to return means OFF
// - a selection of no function makes the input ignored in that mode
// - each input has separate selections for position, velocity and torque modes
// - drive is energised while the energise function is ON, otherwise off
// - an active over-travel inhibit applies the behaviour chosen by the setup register
// - the deviation-clear function resets the positional deviation counter
// - default clear acts on the OFF-to-ON edge; the mode register may change it
// - level mode clears while ON, edge mode once per edge, with minimum widths
// - deviation clear works only on input 7; any other allocation in the active mode raises an error
package cim_pkg;
    localparam int NUM_INPUTS = 10;
    localparam int ADDR_W = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_SEL_BASE = 8'h00;
    localparam logic [7:0] ADDR_OT_SETUP = 8'h28;
    localparam logic [7:0] ADDR_CLR_MODE = 8'h2C;
    localparam logic [7:0] ADDR_STATUS = 8'h30;

    // selection reset values, input 10 first
    localparam logic [NUM_INPUTS-1:0][31:0] SEL_RESET = {
        32'h00000E88, 32'h00050505, 32'h00040404, 32'h00000F07, 32'h00030303,
        32'h0000100C, 32'h00060606, 32'h0091918A, 32'h00818181, 32'h00828282};

    // selection byte layout
    localparam int BYTE_POS_LSB = 0;
    localparam int BYTE_VEL_LSB = 8;
    localparam int BYTE_TRQ_LSB = 16;
    localparam int POL_BIT = 7;

    // control modes
    localparam logic [1:0] MODE_POS = 2'h0;
    localparam logic [1:0] MODE_VEL = 2'h1;
    localparam logic [1:0] MODE_TRQ = 2'h2;
    localparam logic [1:0] MODE_FULL = 2'h3;

    // function codes
    localparam logic [6:0] FN_NONE = 7'h00;
    localparam logic [6:0] FN_POS_LIMIT = 7'h01;
    localparam logic [6:0] FN_NEG_LIMIT = 7'h02;
    localparam logic [6:0] FN_ENERGISE = 7'h03;
    localparam logic [6:0] FN_DEV_RESET = 7'h07;
    localparam int DEV_RESET_INPUT = 6;

    // over-travel response setup
    localparam logic [1:0] OT_BLOCK = 2'h0;
    localparam logic [1:0] OT_DISABLED = 2'h1;
    localparam logic [1:0] OT_QSTOP = 2'h2;
    localparam logic [1:0] OT_RESET = 2'h0;

    // deviation reset mode
    localparam logic [2:0] CLR_LEVEL_500US = 3'h1;
    localparam logic [2:0] CLR_LEVEL_1MS = 3'h2;
    localparam logic [2:0] CLR_EDGE_100US = 3'h3;
    localparam logic [2:0] CLR_EDGE_1MS = 3'h4;
    localparam logic [2:0] CLR_RESET = 3'h3;

    // timing
    localparam int CLK_MHZ = 20;
    localparam int CLR_W_500_US = 500;
    localparam int CLR_W_1MS_US = 1000;
    localparam int CLR_W_100_US = 100;
    localparam int CLR_500_CYC = CLR_W_500_US * CLK_MHZ;
    localparam int CLR_1MS_CYC = CLR_W_1MS_US * CLK_MHZ;
    localparam int CLR_100_CYC = CLR_W_100_US * CLK_MHZ;
    localparam int CLR_CNT_W = 16;

    // status register bits
    localparam int ST_ENERGISE = 0;
    localparam int ST_POS_BLOCK = 1;
    localparam int ST_NEG_BLOCK = 2;
    localparam int ST_QSTOP = 3;
    localparam int ST_ASSIGN_ERR = 4;
    localparam int ST_DEV_CLEAR = 5;
    localparam int ST_PINS_LSB = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cim_pkg

// ### src/cim_input_sync.sv
// Purpose: two-stage synchroniser for the isolated control inputs
// Assumes: inputs are asynchronous levels
// Notes: stage one feeds only stage two
`timescale 1ns/1ns
module cim_input_sync #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cim_sync_t;

    cim_sync_t st_r;
    cim_sync_t st_nxt;

    always_comb begin
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;
endmodule : cim_input_sync

// ### src/cim_mapper.sv
// Purpose: maps ten general control inputs onto drive functions
// Assumes: control_mode comes from logic on aclk; pins are asynchronous
// Notes: deviation clear widths above 4096 cycles are parameters
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module cim_mapper
    import cim_pkg::*;
#(
    parameter int CLR_500_CYCLES = CLR_500_CYC,
    parameter int CLR_1MS_CYCLES = CLR_1MS_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // control inputs, high while connected to the return terminal
    input wire logic general_input_1,
    input wire logic general_input_2,
    input wire logic general_input_3,
    input wire logic general_input_4,
    input wire logic general_input_5,
    input wire logic general_input_6,
    input wire logic general_input_7,
    input wire logic general_input_8,
    input wire logic general_input_9,
    input wire logic general_input_10,
    // active control mode
    input wire logic [1:0] control_mode,
    // drive functions
    output logic drive_energise,
    output logic positive_travel_block,
    output logic negative_travel_block,
    output logic overtravel_quick_stop,
    output logic deviation_counter_clear,
    output logic assign_error
);
    typedef struct packed {
        logic [NUM_INPUTS-1:0][31:0] sel;
        logic [1:0] ot_setup;
        logic [2:0] clr_mode;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [CLR_CNT_W-1:0] clr_cnt;
        logic clr_done;
        logic dev_clear;
        logic energise;
        logic pos_block;
        logic neg_block;
        logic qstop;
        logic assign_err;
    } cim_state_t;

    localparam cim_state_t ST_RESET = '{
        sel: SEL_RESET,
        ot_setup: OT_RESET,
        clr_mode: CLR_RESET,
        default: '0};

    localparam logic [CLR_CNT_W-1:0] W_500 = CLR_CNT_W'(CLR_500_CYCLES);
    localparam logic [CLR_CNT_W-1:0] W_1MS = CLR_CNT_W'(CLR_1MS_CYCLES);
    localparam logic [CLR_CNT_W-1:0] W_100 = CLR_CNT_W'(CLR_100_CYC);

    cim_state_t st_r;
    cim_state_t st_nxt;
    logic [NUM_INPUTS-1:0] pins_async;
    logic [NUM_INPUTS-1:0] pins;

    // selection byte for the active mode
    function automatic logic [7:0] mode_byte(input logic [31:0] v, input logic [1:0] m);
        logic [7:0] b;
        case (m)
            MODE_VEL: b = v[BYTE_VEL_LSB +: 8];
            MODE_TRQ: b = v[BYTE_TRQ_LSB +: 8];
            default: b = v[BYTE_POS_LSB +: 8];
        endcase
        return b;
    endfunction : mode_byte

    // function state from contact polarity and pin level
    function automatic logic fn_state(input logic [7:0] b, input logic pin);
        return b[POL_BIT] ? ~pin : pin;
    endfunction : fn_state

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) begin
                v[k*8 +: 8] = d[k*8 +: 8];
            end
        end
        return v;
    endfunction : merge

    assign pins_async = {general_input_10, general_input_9, general_input_8,
                         general_input_7, general_input_6, general_input_5,
                         general_input_4, general_input_3, general_input_2,
                         general_input_1};

    cim_input_sync #(
        .W(NUM_INPUTS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_async),
        .sync_out(pins)
    );

    always_comb begin
        logic [7:0] b;
        logic [6:0] fn;
        logic on;
        logic drive_energise_input;
        logic pot_on;
        logic not_on;
        logic clr_on;
        logic err;
        logic level_mode;
        logic reached;
        logic [CLR_CNT_W-1:0] width;
        logic [5:0] widx;
        logic [5:0] ridx;
        logic [31:0] rd;
        logic rd_ok;
        b = '0;
        fn = '0;
        on = 1'b0;
        drive_energise_input = 1'b0;
        pot_on = 1'b0;
        not_on = 1'b0;
        clr_on = 1'b0;
        err = 1'b0;
        level_mode = 1'b0;
        reached = 1'b0;
        width = W_100;
        widx = '0;
        ridx = '0;
        rd = '0;
        rd_ok = 1'b0;
        st_nxt = st_r;

        // function routing
        for (int i = 0; i < NUM_INPUTS; i++) begin
            b = mode_byte(st_r.sel[i], control_mode);
            fn = b[6:0];
            on = fn_state(b, pins[i]);
            if (fn != FN_NONE) begin
                if (fn == FN_ENERGISE) begin
                    drive_energise_input = drive_energise_input | on;
                end
                if (fn == FN_POS_LIMIT) begin
                    pot_on = pot_on | on;
                end
                if (fn == FN_NEG_LIMIT) begin
                    not_on = not_on | on;
                end
                if (fn == FN_DEV_RESET) begin
                    if (i == DEV_RESET_INPUT) begin
                        clr_on = clr_on | on;
                    end else begin
                        err = 1'b1;
                    end
                end
            end
        end

        st_nxt.energise = drive_energise_input;
        st_nxt.assign_err = err;
        // over-travel response
        if (st_r.ot_setup == OT_DISABLED) begin
            st_nxt.pos_block = 1'b0;
            st_nxt.neg_block = 1'b0;
            st_nxt.qstop = 1'b0;
        end else begin
            st_nxt.pos_block = pot_on;
            st_nxt.neg_block = not_on;
            st_nxt.qstop = (st_r.ot_setup == OT_QSTOP) & (pot_on | not_on);
        end

        // deviation counter clear
        case (st_r.clr_mode)
            CLR_LEVEL_500US: begin
                level_mode = 1'b1;
                width = W_500;
            end
            CLR_LEVEL_1MS: begin
                level_mode = 1'b1;
                width = W_1MS;
            end
            CLR_EDGE_1MS: begin
                level_mode = 1'b0;
                width = W_1MS;
            end
            default: begin
                level_mode = 1'b0;
                width = W_100;
            end
        endcase
        if (!clr_on) begin
            st_nxt.clr_cnt = '0;
            st_nxt.clr_done = 1'b0;
            st_nxt.dev_clear = 1'b0;
        end else begin
            reached = (st_r.clr_cnt >= width - CLR_CNT_W'(1));
            if (!reached) begin
                st_nxt.clr_cnt = st_r.clr_cnt + CLR_CNT_W'(1);
            end
            if (level_mode) begin
                st_nxt.dev_clear = reached;
            end else begin
                st_nxt.dev_clear = reached & ~st_r.clr_done;
                st_nxt.clr_done = st_r.clr_done | reached;
            end
        end

        // write channel
        if (awvalid && awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            widx = st_r.aw_addr[7:2];
            if (int'(widx) < NUM_INPUTS) begin
                st_nxt.sel[widx] = merge(st_r.sel[widx], st_r.w_data, st_r.w_strb);
            end else if (st_r.aw_addr[7:2] == ADDR_OT_SETUP[7:2]) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.ot_setup = st_r.w_data[1:0];
                end
            end else if (st_r.aw_addr[7:2] == ADDR_CLR_MODE[7:2]) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.clr_mode = st_r.w_data[2:0];
                end
            end else if (st_r.aw_addr[7:2] != ADDR_STATUS[7:2]) begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end

        // read channel
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            ridx = araddr[7:2];
            rd_ok = 1'b1;
            if (int'(ridx) < NUM_INPUTS) begin
                rd = st_r.sel[ridx];
            end else if (araddr[7:2] == ADDR_OT_SETUP[7:2]) begin
                rd = {30'h0, st_r.ot_setup};
            end else if (araddr[7:2] == ADDR_CLR_MODE[7:2]) begin
                rd = {29'h0, st_r.clr_mode};
            end else if (araddr[7:2] == ADDR_STATUS[7:2]) begin
                rd[ST_ENERGISE] = st_r.energise;
                rd[ST_POS_BLOCK] = st_r.pos_block;
                rd[ST_NEG_BLOCK] = st_r.neg_block;
                rd[ST_QSTOP] = st_r.qstop;
                rd[ST_ASSIGN_ERR] = st_r.assign_err;
                rd[ST_DEV_CLEAR] = st_r.dev_clear;
                rd[ST_PINS_LSB +: NUM_INPUTS] = pins;
            end else begin
                rd_ok = 1'b0;
            end
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // handshakes
    assign awready = ~st_r.aw_have & ~st_r.bvalid;
    assign wready = ~st_r.w_have & ~st_r.bvalid;
    assign arready = ~st_r.rvalid;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;

    // functions
    assign drive_energise = st_r.energise;
    assign positive_travel_block = st_r.pos_block;
    assign negative_travel_block = st_r.neg_block;
    assign overtravel_quick_stop = st_r.qstop;
    assign deviation_counter_clear = st_r.dev_clear;
    assign assign_error = st_r.assign_err;
endmodule : cim_mapper

// ### testbench/cim_mapper_asserts.sv
// Purpose: port-level assertions for cim_mapper
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound into every cim_mapper instance
`timescale 1ns/1ns
module cim_mapper_asserts
    import cim_pkg::*;
#(
    parameter int CLR_500_CYCLES = CLR_500_CYC,
    parameter int CLR_1MS_CYCLES = CLR_1MS_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // pins and functions
    input wire logic general_input_7,
    input wire logic drive_energise,
    input wire logic positive_travel_block,
    input wire logic negative_travel_block,
    input wire logic overtravel_quick_stop,
    input wire logic deviation_counter_clear
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since the clear pin last changed, saturating
    logic in7_q;
    logic [15:0] still_r;
    always_ff @(posedge aclk) begin
        in7_q <= general_input_7;
        if (!aresetn || general_input_7 != in7_q) still_r <= 16'h0000;
        else if (still_r != 16'hFFFF) still_r <= still_r + 16'h0001;
    end
    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence read_taken;
        arvalid && arready;
    endsequence
    write_answer_a: assert property (both_taken |-> ##2 bvalid)
        else $error("write response not on time");
    bvalid_release_a: assert property ($fell(bvalid) |-> $past(bready))
        else $error("bvalid dropped without bready");
    read_answer_a: assert property (read_taken |=> rvalid)
        else $error("read data not on time");
    rvalid_release_a: assert property ($fell(rvalid) |-> $past(rready))
        else $error("rvalid dropped without rready");
    write_refuse_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    read_refuse_a: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
    qstop_needs_a: assert property (
        overtravel_quick_stop |-> positive_travel_block || negative_travel_block)
        else $error("quick stop without a travel limit");
    clear_width_a: assert property (
        $rose(deviation_counter_clear) |-> $past(still_r, 3) >= CLR_500_CYCLES - 4)
        else $error("clear without a wide enough pulse on input 7");
    reset_quiet_a: assert property ($rose(aresetn) |-> !drive_energise
        && !positive_travel_block && !negative_travel_block && !deviation_counter_clear)
        else $error("function active straight after reset");
endmodule : cim_mapper_asserts

bind cim_mapper cim_mapper_asserts #(.CLR_500_CYCLES(CLR_500_CYCLES),
    .CLR_1MS_CYCLES(CLR_1MS_CYCLES)) chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .general_input_7(general_input_7),
    .drive_energise(drive_energise), .positive_travel_block(positive_travel_block),
    .negative_travel_block(negative_travel_block),
    .overtravel_quick_stop(overtravel_quick_stop),
    .deviation_counter_clear(deviation_counter_clear));

// ### testbench/cim_mapper_tb_top.sv
// Purpose: self-checking bench for cim_mapper
// Assumes: 20 MHz aclk, switch model on the ten inputs
// Notes: 500 us and 1 ms clear widths shortened to 20 and 40 cycles
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module cim_mapper_tb_top
    import cim_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, mid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, seed, rnd, d, v;
    logic [1:0] bresp, rresp, r, ot, control_mode = 2'h0;
    logic [9:0] on_req = 10'h000, b_pol = 10'h000, pins;
    logic energise, pos_blk, neg_blk, qstop, dev_clr, asg_err;
    logic [31:0] sel [NUM_INPUTS];
    int fail_count = 0, checked = 0, cyc = 0, hi_cnt = 0, base, i;

    initial forever #25 aclk = ~aclk;

    cim_switch_model sw (.aclk(aclk), .on_req(on_req), .b_contact(b_pol), .pins(pins));
    cim_mapper #(.CLR_500_CYCLES(20), .CLR_1MS_CYCLES(40)) uut (.aclk(aclk),
        .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .general_input_1(pins[0]),
        .general_input_2(pins[1]), .general_input_3(pins[2]), .general_input_4(pins[3]),
        .general_input_5(pins[4]), .general_input_6(pins[5]), .general_input_7(pins[6]),
        .general_input_8(pins[7]), .general_input_9(pins[8]), .general_input_10(pins[9]),
        .control_mode(control_mode), .drive_energise(energise),
        .positive_travel_block(pos_blk), .negative_travel_block(neg_blk),
        .overtravel_quick_stop(qstop), .deviation_counter_clear(dev_clr),
        .assign_error(asg_err));

    always @(posedge aclk) begin
        if (dev_clr === 1'h1) hi_cnt <= hi_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            $display("wrong value cycle limit exp %0d got %0d", 30000, cyc);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [31:0] val, output logic [1:0] resp);
        logic ah, wh, bh;
        bh = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= val;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!bh) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] val, output logic [1:0] resp);
        logic ah, rh;
        rh = 1'h0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!rh) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid;
            val = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask : rd

    // holds the clear input on for n cycles, sampling the clear output near the end
    task automatic press(input int n, output logic m);
        @(posedge aclk);
        on_req[DEV_RESET_INPUT] <= 1'h1;
        repeat (n - 5) @(posedge aclk);
        @(negedge aclk);
        m = dev_clr;
        repeat (5) @(posedge aclk);
        on_req[DEV_RESET_INPUT] <= 1'h0;
        repeat (8) @(posedge aclk);
    endtask : press

    function automatic logic [4:0] expect_fn(input logic [1:0] m, input logic [9:0] p);
        logic [4:0] e;
        logic [7:0] b;
        int sh;
        e = 5'h00;
        sh = (m == MODE_FULL) ? 0 : 8 * m;
        for (int k = 0; k < NUM_INPUTS; k++) begin
            b = sel[k][sh +: 8];
            if (b[6:0] == FN_ENERGISE) e[0] = e[0] | (p[k] ^ b[POL_BIT]);
            if (b[6:0] == FN_POS_LIMIT) e[1] = e[1] | (p[k] ^ b[POL_BIT]);
            if (b[6:0] == FN_NEG_LIMIT) e[2] = e[2] | (p[k] ^ b[POL_BIT]);
            if (b[6:0] == FN_DEV_RESET && k != DEV_RESET_INPUT) e[4] = 1'h1;
        end
        if (ot == OT_DISABLED) e[2:1] = 2'h0;
        e[3] = (ot == OT_QSTOP) && (e[1] || e[2]);
        return e;
    endfunction : expect_fn

    function automatic logic [7:0] pick(input logic [7:0] x);
        logic [6:0] c [5] = '{FN_NONE, FN_POS_LIMIT, FN_NEG_LIMIT, FN_ENERGISE, FN_DEV_RESET};
        return {x[7], c[x[2:0] % 5]};
    endfunction : pick

    task automatic apply(input logic [9:0] o, input logic [9:0] p, input logic [1:0] m);
        @(posedge aclk);
        on_req <= o;
        b_pol <= p;
        control_mode <= m;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        `CHK("functions", expect_fn(m, o ^ p), {asg_err, qstop, neg_blk, pos_blk, energise})
        rd(ADDR_STATUS, d, r);
        `CHK("status", {6'h00, o ^ p, 10'h000, 1'h0, expect_fn(m, o ^ p)}, d)
    endtask : apply

    initial begin
        seed = 32'h6331;
        ot = OT_RESET;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < NUM_INPUTS; i++) begin
            sel[i] = SEL_RESET[i];
            rd(ADDR_SEL_BASE + 8'(4 * i), d, r);
            `CHK("selection reset", SEL_RESET[i], d)
        end
        rd(ADDR_OT_SETUP, d, r);
        `CHK("setup reset", {30'h0, OT_RESET}, d)
        rd(ADDR_CLR_MODE, d, r);
        `CHK("clear mode reset", {29'h0, CLR_RESET}, d)
        rd(8'h34, d, r);
        `CHK("unmapped read", RESP_SLVERR, r)
        wr(8'h34, 32'h0, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        $display("test registers done");
        base = hi_cnt;
        press(2100, mid);
        `CHK("edge clear cycles", 1, hi_cnt - base)
        base = hi_cnt;
        press(1000, mid);
        `CHK("short clear cycles", 0, hi_cnt - base)
        wr(ADDR_CLR_MODE, {29'h0, CLR_LEVEL_1MS}, r);
        press(30, mid);
        `CHK("short level clear", 1'h0, mid)
        wr(ADDR_CLR_MODE, {29'h0, CLR_EDGE_1MS}, r);
        base = hi_cnt;
        press(100, mid);
        `CHK("long edge clear cycles", 1, hi_cnt - base)
        wr(ADDR_CLR_MODE, {29'h0, CLR_LEVEL_500US}, r);
        press(100, mid);
        `CHK("level clear", 1'h1, mid)
        `CHK("level clear released", 1'h0, dev_clr)
        control_mode <= MODE_TRQ;
        press(100, mid);
        `CHK("clear ignored in torque", 1'h0, mid)
        wr(ADDR_CLR_MODE, {29'h0, CLR_RESET}, r);
        $display("test clear done");
        apply(10'h020, 10'h000, MODE_POS);
        apply(10'h023, 10'h003, MODE_FULL);
        for (int k = 0; k < 40; k++) begin
            rnd = $random(seed);
            v = {8'h00, pick(rnd[7:0]), pick(rnd[15:8]), pick(rnd[23:16])};
            i = rnd[31:28] % 10;
            sel[i] = v;
            wr(ADDR_SEL_BASE + 8'(4 * i), v, r);
            `CHK("selection write response", RESP_OKAY, r)
            rd(ADDR_SEL_BASE + 8'(4 * i), d, r);
            `CHK("selection readback", v, d)
            ot = 2'(rnd[27:26] % 3);
            wr(ADDR_OT_SETUP, {30'h0, ot}, r);
            rnd = $random(seed);
            apply(rnd[9:0], rnd[19:10], rnd[21:20]);
        end
        $display("test mapping done");
        give_verdict();
    end
endmodule : cim_mapper_tb_top

// ### testbench/cim_switch_model.sv
// Purpose: switches and host lines on the ten control inputs
// Assumes: a request reaches its pin one aclk edge later
// Notes: pin high means contact closed to the return terminal
`timescale 1ns/1ns
module cim_switch_model (
    // clock
    input wire logic aclk,
    // wanted function state and wiring polarity per input
    input wire logic [9:0] on_req,
    input wire logic [9:0] b_contact,
    // pins toward the mapper
    output logic [9:0] pins
);
    initial pins = 10'h000;
    // a-contact closes to turn on, b-contact opens; limit switches turn on past the end
    always @(posedge aclk) begin
        pins <= on_req ^ b_contact;
    end
endmodule : cim_switch_model
